// file: aitc_top.sv
// Auxiliary input capture, trigger comparator and its APB register file.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module aitc_top (
   input wire logic i_clk, // 250 MHz clock.
   input wire logic i_reset, // Asynchronous reset, active high.
   input wire logic i_psel, // APB select.
   input wire logic i_penable, // APB enable.
   input wire logic i_pwrite, // APB write direction.
   input wire logic [11:0] i_paddr, // APB byte address.
   input wire logic [31:0] i_pwdata, // APB write data.
   output logic [31:0] o_prdata, // APB read data.
   output logic o_pready, // APB ready.
   output logic o_pslverr, // APB error on unmapped address.
   input wire logic i_cycle_strobe, // One pulse per bus cycle to capture.
   input wire logic [19:0] i_addr, // Bus address of the cycle.
   input wire logic [15:0] i_data, // Bus data of the cycle.
   input wire logic [3:0] i_ctl, // Bus control lines of the cycle.
   input wire logic [7:0] i_aux, // Auxiliary probe pins, asynchronous.
   output aitc_pkg::aitc_trace_t o_trace_word, // Captured 48-bit trace word.
   output logic o_trace_valid, // Pulse: trace word is new.
   output logic [39:0] o_qual_word, // Word seen by qualifier and filter.
   output logic o_trigger, // Pulse: trigger match on the last cycle.
   output logic o_irq // Level interrupt.
);
   logic [7:0] aux_meta;
   logic [7:0] aux_sync;
   logic enable;
   aitc_pkg::aitc_cfg_t cfg;
   logic [aitc_pkg::STAT_W-1:0] status;
   logic [aitc_pkg::STAT_W-1:0] irq_mask;
   logic [aitc_pkg::CNT_W-1:0] match_cnt;
   logic hit;
   logic setup;
   logic wr;
   logic rd;
   logic [31:0] next_rdata;
   logic next_err;
   logic status_read;
   logic [aitc_pkg::STAT_W-1:0] stat_set;
   logic [aitc_pkg::STAT_W-1:0] stat_clr;

   // The pins are asynchronous; only the second stage is ever read.
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         aux_meta <= 8'h00;
         aux_sync <= 8'h00;
      end
      else
      begin
         aux_meta <= i_aux;
         aux_sync <= aux_meta;
      end
   end

   // Capture the full cycle; the comparator then works on this very word.
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_trace_word <= '0;
         o_trace_valid <= 1'b0;
      end
      else
      begin
         o_trace_valid <= i_cycle_strobe;
         if (i_cycle_strobe)
         begin
            o_trace_word <= {aux_sync, i_ctl, i_data, i_addr};
         end
      end
   end

   // Qualifier and filter never see the auxiliary byte.
   assign o_qual_word = {o_trace_word.ctl, o_trace_word.data, o_trace_word.addr};

   aitc_byte_match u_match (
      .i_byte(o_trace_word.aux),
      .i_cfg(cfg),
      .o_hit(hit)
   );

   // One trigger decision per captured word, registered for a clean pulse.
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_trigger <= 1'b0;
      end
      else
      begin
         o_trigger <= o_trace_valid && enable && hit;
      end
   end

   // Count of trigger matches, wraps silently.
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         match_cnt <= '0;
      end
      else if (o_trigger)
      begin
         match_cnt <= match_cnt + 16'h0001;
      end
   end

   // APB phases; the slave never stalls, so every access ends in one cycle.
   assign setup = i_psel && !i_penable;
   assign wr = i_psel && i_penable && i_pwrite;
   assign rd = i_psel && i_penable && !i_pwrite;
   assign o_pready = 1'b1;

   // Software settings.
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         enable <= 1'b0;
         cfg.mode <= aitc_pkg::MODE_SINGLE;
         cfg.invert <= 1'b0;
         cfg.field <= aitc_pkg::FIELD_AUX;
         cfg.value <= aitc_pkg::RST_BYTE;
         cfg.bound <= aitc_pkg::RST_BYTE;
         cfg.care <= aitc_pkg::RST_CARE;
         cfg.alt <= aitc_pkg::RST_WORD;
         cfg.alt_en <= '0;
         irq_mask <= '0;
      end
      else if (wr)
      begin
         case (i_paddr)
            aitc_pkg::OFF_CTRL:
            begin
               enable <= i_pwdata[aitc_pkg::CTRL_EN_BIT];
               cfg.mode <= aitc_pkg::aitc_mode_t'(i_pwdata[aitc_pkg::CTRL_MODE_LSB +: 2]);
               cfg.invert <= i_pwdata[aitc_pkg::CTRL_INV_BIT];
               cfg.field <= aitc_pkg::aitc_field_t'(i_pwdata[aitc_pkg::CTRL_FIELD_LSB +: 3]);
            end
            aitc_pkg::OFF_VALUE: cfg.value <= i_pwdata[7:0];
            aitc_pkg::OFF_BOUND: cfg.bound <= i_pwdata[7:0];
            aitc_pkg::OFF_CARE: cfg.care <= i_pwdata[7:0];
            aitc_pkg::OFF_ALT: cfg.alt <= i_pwdata;
            aitc_pkg::OFF_ALT_EN: cfg.alt_en <= i_pwdata[aitc_pkg::ALT_N-1:0];
            aitc_pkg::OFF_IRQ_MASK: irq_mask <= i_pwdata[aitc_pkg::STAT_W-1:0];
            default:
            begin
            end
         endcase
      end
   end

   // Read data and error are prepared in the setup phase and held for access.
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      case (i_paddr)
         aitc_pkg::OFF_CTRL:
            next_rdata[6:0] = {cfg.field, cfg.invert, cfg.mode, enable};
         aitc_pkg::OFF_VALUE: next_rdata[7:0] = cfg.value;
         aitc_pkg::OFF_BOUND: next_rdata[7:0] = cfg.bound;
         aitc_pkg::OFF_CARE: next_rdata[7:0] = cfg.care;
         aitc_pkg::OFF_ALT: next_rdata = cfg.alt;
         aitc_pkg::OFF_ALT_EN: next_rdata[aitc_pkg::ALT_N-1:0] = cfg.alt_en;
         aitc_pkg::OFF_STATUS: next_rdata[aitc_pkg::STAT_W-1:0] = status;
         aitc_pkg::OFF_IRQ_MASK: next_rdata[aitc_pkg::STAT_W-1:0] = irq_mask;
         aitc_pkg::OFF_TRACE_LO: next_rdata = o_trace_word[31:0];
         aitc_pkg::OFF_TRACE_HI: next_rdata[15:0] = o_trace_word[47:32];
         aitc_pkg::OFF_MATCH_CNT: next_rdata[aitc_pkg::CNT_W-1:0] = match_cnt;
         default: next_err = 1'b1;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else if (setup)
      begin
         o_prdata <= next_rdata;
         o_pslverr <= next_err;
      end
   end

   // Only bits that software actually saw are cleared, so an event landing
   // between setup and access is kept, and a set always beats a clear.
   assign status_read = rd && (i_paddr == aitc_pkg::OFF_STATUS);
   assign stat_clr = status_read ? o_prdata[aitc_pkg::STAT_W-1:0] : '0;
   assign stat_set = {o_trace_valid, o_trigger};

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         status <= '0;
      end
      else
      begin
         status <= (status & ~stat_clr) | stat_set;
      end
   end

   // Interrupt is a level while any unmasked status bit stands.
   assign o_irq = |(status & irq_mask);

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   sequence capture_s;
      i_cycle_strobe ##1 o_trace_valid;
   endsequence

   sequence aux_eval_s;
      o_trace_valid && enable;
   endsequence

   // A bus access: the setup cycle, then the access cycle that completes it.
   sequence apb_access_s;
      setup ##1 (i_psel && i_penable);
   endsequence

   // The trace word must hold the synchronised pins of the strobe edge.
   capture_aux_a: assert property (capture_s |-> o_trace_word.aux == $past(aux_sync))
      else $error("Auxiliary byte not stored from the sampled pins.");
   // Trigger checks look one cycle after the word is shown, when the registered decision stands.
   single_hit_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_SINGLE && !cfg.invert)
      |=> o_trigger == $past(o_trace_word.aux == cfg.value))
      else $error("Single-value match wrong.");
   range_hit_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_RANGE && !cfg.invert
      && o_trace_word.aux >= cfg.value && o_trace_word.aux <= cfg.bound) |=> o_trigger)
      else $error("Inclusive range missed.");
   invert_miss_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_SINGLE && cfg.invert
      && o_trace_word.aux == cfg.value) |=> !o_trigger)
      else $error("Inverted match fired on the value.");
   care_ignore_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_MASK
      && cfg.field == aitc_pkg::FIELD_AUX)
      |=> o_trigger == $past(((o_trace_word.aux ^ cfg.value) & cfg.care) == 8'h00))
      else $error("Masked match wrong.");
   care_field_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_MASK
      && cfg.field != aitc_pkg::FIELD_AUX && o_trace_word.aux != cfg.value) |=> !o_trigger)
      else $error("Care byte of another field used.");
   line_map_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_MASK
      && cfg.field == aitc_pkg::FIELD_AUX && cfg.care == 8'h03 && cfg.value == 8'h02)
      |=> o_trigger == $past(o_trace_word.aux[1] && !o_trace_word.aux[0]))
      else $error("Line order in compare byte wrong.");
   alt_hit_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_ALT
      && cfg.alt_en[0] && o_trace_word.aux == cfg.alt[0]) |=> o_trigger)
      else $error("Alternative value missed.");
   qual_clean_a: assert property (capture_s |-> o_qual_word == {$past(i_ctl), $past(i_data), $past(i_addr)})
      else $error("Qualifier word carries auxiliary bits.");
   once_per_a: assert property (o_trigger |-> $past(o_trace_valid))
      else $error("Trigger without a captured cycle.");
   irq_level_a: assert property (status[aitc_pkg::STAT_MATCH_BIT] && irq_mask[aitc_pkg::STAT_MATCH_BIT] |-> o_irq)
      else $error("Interrupt low with unmasked status.");

   // Misses: outside the range, inside it when inverted, on no listed value; a hit off the value when inverted.
   range_miss_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_RANGE && !cfg.invert
      && (o_trace_word.aux < cfg.value || o_trace_word.aux > cfg.bound)) |=> !o_trigger)
      else $error("Range matched outside its bounds.");
   invert_range_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_RANGE && cfg.invert
      && o_trace_word.aux >= cfg.value && o_trace_word.aux <= cfg.bound) |=> !o_trigger)
      else $error("Inverted range fired inside its bounds.");
   invert_hit_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_SINGLE && cfg.invert
      && o_trace_word.aux != cfg.value) |=> o_trigger)
      else $error("Inverted match missed a different byte.");
   alt_miss_a: assert property (aux_eval_s ##0 (cfg.mode == aitc_pkg::MODE_ALT
      && !(cfg.alt_en[0] && o_trace_word.aux == cfg.alt[0]) && !(cfg.alt_en[1] && o_trace_word.aux == cfg.alt[1])
      && !(cfg.alt_en[2] && o_trace_word.aux == cfg.alt[2]) && !(cfg.alt_en[3] && o_trace_word.aux == cfg.alt[3]))
      |=> !o_trigger)
      else $error("Alternative list fired on an unlisted byte.");

   // A switched-off comparator stays quiet, and the trace word only moves on a strobe.
   disabled_quiet_a: assert property (!enable |=> !o_trigger)
      else $error("Trigger while the comparator is off.");
   trace_hold_a: assert property (!i_cycle_strobe |=> $stable(o_trace_word))
      else $error("Trace word changed without a strobe.");

   // Status records every capture and match, and a read clears what it showed unless a set lands.
   status_cap_a: assert property (o_trace_valid |=> status[aitc_pkg::STAT_CAP_BIT])
      else $error("Capture not recorded in status.");
   status_match_a: assert property (o_trigger |=> status[aitc_pkg::STAT_MATCH_BIT])
      else $error("Match not recorded in status.");
   read_clear_a: assert property (status_read && stat_set == '0
      |=> (status & $past(o_prdata[aitc_pkg::STAT_W-1:0])) == '0)
      else $error("Status read left shown bits set.");
   count_step_a: assert property (o_trigger |=> match_cnt == $past(match_cnt) + 16'h0001)
      else $error("Match count did not advance.");
   // A write lands at the access edge of its own transfer.
   value_write_a: assert property (apb_access_s ##0 (i_pwrite && i_paddr == aitc_pkg::OFF_VALUE)
      |=> cfg.value == $past(i_pwdata[7:0]))
      else $error("Compare value write lost.");
endmodule : aitc_top

// file: aitc_pkg.sv
// Package with constants and types of the auxiliary input trigger comparator.
// Function
// - Each captured cycle stores eight auxiliary bits in the 48-bit trace word.
// - Care-select byte has one bit per line; one compares, zero ignores.
// - Compare bits at ignored positions never affect the match result.
// - Care-select applies only to the field it names, here the auxiliary field.
// - Masked compare is never combined with range, inversion or alternative values.
// - Single-value mode matches when all eight lines equal the programmed byte.
// - Range mode matches when the byte lies between both bounds inclusive.
// - Inverted mode matches only when the byte is outside value or range.
// - Qualifier and filter outputs exclude auxiliary lines; the trigger still uses them.
// - Auxiliary line n maps to bit n of compare and care bytes.
// - Alternative-value mode matches when the byte equals any enabled listed value.
package aitc_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int CTL_W = 4;
   localparam int AUX_W = 8;
   localparam int ALT_N = 4;
   localparam int QUAL_W = ADDR_W + DATA_W + CTL_W;
   localparam int CNT_W = 16;

   // Register byte offsets on the APB.
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_VALUE = 12'h004;
   localparam logic [11:0] OFF_BOUND = 12'h008;
   localparam logic [11:0] OFF_CARE = 12'h00C;
   localparam logic [11:0] OFF_ALT = 12'h010;
   localparam logic [11:0] OFF_ALT_EN = 12'h014;
   localparam logic [11:0] OFF_STATUS = 12'h018;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;
   localparam logic [11:0] OFF_TRACE_LO = 12'h020;
   localparam logic [11:0] OFF_TRACE_HI = 12'h024;
   localparam logic [11:0] OFF_MATCH_CNT = 12'h028;

   // Field positions inside the control and status registers.
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_INV_BIT = 3;
   localparam int CTRL_FIELD_LSB = 4;
   localparam int STAT_MATCH_BIT = 0;
   localparam int STAT_CAP_BIT = 1;
   localparam int STAT_W = 2;

   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_CARE = 8'hFF;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_RANGE = 2'b01,
      MODE_MASK = 2'b10,
      MODE_ALT = 2'b11
   } aitc_mode_t;

   typedef enum logic [2:0] {
      FIELD_ADDR = 3'b000,
      FIELD_CTL = 3'b001,
      FIELD_DATA = 3'b010,
      FIELD_HI_ADDR = 3'b011,
      FIELD_HI_DATA = 3'b100,
      FIELD_LO_ADDR = 3'b101,
      FIELD_AUX = 3'b110
   } aitc_field_t;

   // One captured bus cycle, auxiliary byte on top.
   typedef struct packed {
      logic [AUX_W-1:0] aux;
      logic [CTL_W-1:0] ctl;
      logic [DATA_W-1:0] data;
      logic [ADDR_W-1:0] addr;
   } aitc_trace_t;

   // Trigger settings for the auxiliary field.
   typedef struct packed {
      aitc_mode_t mode;
      logic invert;
      aitc_field_t field;
      logic [AUX_W-1:0] value;
      logic [AUX_W-1:0] bound;
      logic [AUX_W-1:0] care;
      logic [ALT_N-1:0][AUX_W-1:0] alt;
      logic [ALT_N-1:0] alt_en;
   } aitc_cfg_t;
endpackage : aitc_pkg

// file: aitc_byte_match.sv
// Combinational trigger compare of one auxiliary byte against its settings.
`timescale 1ns/1ns
module aitc_byte_match (
   input wire logic [7:0] i_byte, // Captured auxiliary byte.
   input wire aitc_pkg::aitc_cfg_t i_cfg, // Trigger settings.
   output logic o_hit // Byte satisfies the settings.
);
   logic [aitc_pkg::ALT_N-1:0] alt_hit;
   logic [7:0] care;

   // Each alternative value is its own equality term.
   genvar g;
   generate
      for (g = 0; g < aitc_pkg::ALT_N; g++)
      begin : g_alt
         assign alt_hit[g] = i_cfg.alt_en[g] && (i_byte == i_cfg.alt[g]);
      end
   endgenerate

   // The care byte only counts when it was given for the auxiliary field.
   assign care = (i_cfg.field == aitc_pkg::FIELD_AUX) ? i_cfg.care : 8'hFF;

   // Mode decode; the masked form ignores inversion by construction.
   always_comb
   begin
      case (i_cfg.mode)
         aitc_pkg::MODE_SINGLE: o_hit = (i_byte == i_cfg.value) ^ i_cfg.invert;
         aitc_pkg::MODE_RANGE:
            o_hit = ((i_byte >= i_cfg.value) && (i_byte <= i_cfg.bound)) ^ i_cfg.invert;
         aitc_pkg::MODE_MASK: o_hit = ((i_byte ^ i_cfg.value) & care) == 8'h00;
         aitc_pkg::MODE_ALT: o_hit = |alt_hit;
         default: o_hit = 1'b0;
      endcase
   end
endmodule : aitc_byte_match

// file: aitc_probe_model.sv
// Target-board model driving the auxiliary probe pins and the bus-cycle fields.
`timescale 1ns/1ns
module aitc_probe_model (
   input wire logic i_clk, // Clock.
   input wire logic i_go, // Start one bus cycle.
   input wire aitc_pkg::aitc_trace_t i_word, // Values to present, held by the bench.
   output logic o_strobe = 1'b0, // Capture pulse.
   output logic [19:0] o_addr = 20'h0_0000, // Address lines.
   output logic [15:0] o_data = 16'h0000, // Data lines.
   output logic [3:0] o_ctl = 4'h0, // Control lines.
   output logic [7:0] o_aux = 8'h00 // Probe pins.
);
   logic [2:0] wait_cnt = 3'd0;
   // Probes change at once, but the strobe waits three edges so the pin synchroniser has settled.
   // A released bus does not hold its last value, so the fields show its inverse outside the strobe.
   always_ff @(posedge i_clk)
   begin
      o_strobe <= 1'b0;
      if (i_go)
      begin
         o_aux <= i_word.aux;
         wait_cnt <= 3'd3;
      end
      else if (wait_cnt != 3'd0)
      begin
         wait_cnt <= wait_cnt - 3'd1;
         o_strobe <= (wait_cnt == 3'd1);
         o_addr <= (wait_cnt == 3'd1) ? i_word.addr : ~i_word.addr;
         o_data <= (wait_cnt == 3'd1) ? i_word.data : ~i_word.data;
         o_ctl <= (wait_cnt == 3'd1) ? i_word.ctl : ~i_word.ctl;
      end
      else if (o_strobe)
      begin
         o_addr <= ~o_addr;
         o_data <= ~o_data;
         o_ctl <= ~o_ctl;
      end
   end
endmodule : aitc_probe_model

// file: aux_input_trigger_compare_bench.sv
// Self-checking bench of the auxiliary input trigger comparator.
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value %0s expected %h seen %h", n, e, g); end end
module aux_input_trigger_compare_bench;
   logic i_clk, i_reset, psel, penable, pwrite, go, strobe, on, inv, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, o_prdata, r, rv, alt;
   logic o_pready, o_pslverr, o_trace_valid, o_trigger, o_irq;
   logic [19:0] addr;
   logic [15:0] data;
   logic [3:0] ctl, en;
   logic [7:0] aux, val, bnd, care;
   logic [1:0] mode;
   logic [2:0] fld;
   aitc_pkg::aitc_trace_t last;
   int hits = 0;
   logic [39:0] o_qual_word;
   aitc_pkg::aitc_trace_t word, o_trace_word;
   integer seed = 32'hab4f;
   int err_total = 0;
   int samples_checked = 0;
   aitc_probe_model i_probe (.i_clk(i_clk), .i_go(go), .i_word(word), .o_strobe(strobe), .o_addr(addr),
      .o_data(data), .o_ctl(ctl), .o_aux(aux));
   aitc_top i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_cycle_strobe(strobe), .i_addr(addr), .i_data(data), .i_ctl(ctl), .i_aux(aux),
      .o_trace_word(o_trace_word), .o_trace_valid(o_trace_valid), .o_qual_word(o_qual_word),
      .o_trigger(o_trigger), .o_irq(o_irq));
   // Prints the counts and the verdict, then stops the run.
   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   // One APB transfer; the request stands until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do begin @(posedge i_clk); end while (o_pready !== 1'b1);
      r = o_prdata;
      e = o_pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0000_0000);
      `CHK("read data", x, r)
      `CHK("slave error", xe, e)
   endtask : rd
   // Loads the whole trigger setup; the care field is the one held in fld.
   task automatic cfg();
      apb(1'b1, aitc_pkg::OFF_CTRL, {25'd0, fld, inv, mode, on});
      apb(1'b1, aitc_pkg::OFF_VALUE, {24'd0, val});
      apb(1'b1, aitc_pkg::OFF_BOUND, {24'd0, bnd});
      apb(1'b1, aitc_pkg::OFF_CARE, {24'd0, care});
      apb(1'b1, aitc_pkg::OFF_ALT, alt);
      apb(1'b1, aitc_pkg::OFF_ALT_EN, {28'd0, en});
   endtask : cfg
   // Expected trigger decision for one auxiliary byte under the current setup.
   function automatic logic exp_hit(input logic [7:0] a);
      logic h;
      case (mode)
         2'd0: h = (a == val) ^ inv;
         2'd1: h = ((a >= val) && (a <= bnd)) ^ inv;
         2'd2: h = ((a ^ val) & ((fld == 3'd6) ? care : 8'hFF)) == 8'h00;
         default: h = (en[0] && alt[7:0] == a) || (en[1] && alt[15:8] == a) ||
            (en[2] && alt[23:16] == a) || (en[3] && alt[31:24] == a);
      endcase
      return h & on;
   endfunction : exp_hit
   // One bus cycle through the probes, then checks of capture, qualifier word and trigger.
   task automatic run(input logic [7:0] x);
      logic [63:0] rr;
      rr = {$random(seed), $random(seed)};
      last = {x, rr[39:0]};
      @(posedge i_clk);
      go <= 1'b1;
      word <= last;
      @(posedge i_clk);
      go <= 1'b0;
      do begin @(posedge i_clk); #1; end while (o_trace_valid !== 1'b1);
      `CHK("trace word", {x, rr[39:0]}, o_trace_word)
      `CHK("qualifier word", rr[39:0], o_qual_word)
      @(posedge i_clk);
      #1;
      `CHK("trigger", exp_hit(x), o_trigger)
      if (exp_hit(x))
         hits++;
   endtask : run
   task automatic tc(input logic [1:0] m, input logic iv, input logic [7:0] v, b, c, x);
      mode = m;
      inv = iv;
      val = v;
      bnd = b;
      care = c;
      cfg();
      run(x);
   endtask : tc
   // Free-running clock.
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // Cuts a hung run short.
   initial
   begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      results();
   end
   // Main sequence: reset values, corner cases, random trials, interrupt path.
   initial
   begin
      {i_reset, psel, penable, pwrite, go, on, inv, mode, en} = 13'h1000;
      fld = 3'd6;
      {paddr, pwdata, alt, word, val, bnd, care} = '0;
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      rd(aitc_pkg::OFF_CTRL, 32'h0000_0060, 1'b0);
      rd(aitc_pkg::OFF_CARE, 32'h0000_00FF, 1'b0);
      rd(aitc_pkg::OFF_STATUS, 32'h0000_0000, 1'b0);
      rd(12'h040, 32'h0000_0000, 1'b1);
      $display("test reset done");
      on = 1'b1;
      tc(2'd0, 1'b0, 8'h12, 8'h00, 8'hFF, 8'h12);
      tc(2'd0, 1'b1, 8'h12, 8'h00, 8'hFF, 8'h12);
      tc(2'd1, 1'b0, 8'h12, 8'h34, 8'hFF, 8'h12);
      tc(2'd1, 1'b0, 8'h12, 8'h34, 8'hFF, 8'h34);
      tc(2'd1, 1'b0, 8'h12, 8'h34, 8'hFF, 8'h35);
      tc(2'd1, 1'b1, 8'h12, 8'h34, 8'hFF, 8'h11);
      tc(2'd2, 1'b0, 8'h01, 8'h00, 8'h01, 8'hF1);
      tc(2'd2, 1'b0, 8'hFF, 8'h00, 8'h01, 8'h01);
      tc(2'd2, 1'b0, 8'h02, 8'h00, 8'h03, 8'h02);
      tc(2'd2, 1'b0, 8'h02, 8'h00, 8'h03, 8'h03);
      tc(2'd2, 1'b0, 8'hFF, 8'h00, 8'h03, 8'h7B);
      tc(2'd2, 1'b1, 8'h02, 8'h00, 8'h03, 8'h02);
      fld = 3'd0;
      tc(2'd2, 1'b0, 8'h01, 8'h00, 8'h01, 8'hF1);
      fld = 3'd6;
      alt = 32'h0000_4523;
      en = 4'h3;
      tc(2'd3, 1'b0, 8'h00, 8'h00, 8'hFF, 8'h23);
      tc(2'd3, 1'b0, 8'h00, 8'h00, 8'hFF, 8'h45);
      tc(2'd3, 1'b0, 8'h00, 8'h00, 8'hFF, 8'h46);
      on = 1'b0;
      tc(2'd0, 1'b0, 8'h12, 8'h00, 8'hFF, 8'h12);
      $display("test corners done");
      on = 1'b1;
      repeat (40)
      begin
         rv = $random(seed);
         alt = $random(seed);
         en = rv[6:3];
         tc(rv[1:0], rv[2], rv[15:8], rv[23:16], rv[31:24], rv[7] ? rv[15:8] : 8'(alt >> 4));
      end
      $display("test random done");
      apb(1'b0, aitc_pkg::OFF_STATUS, 32'h0000_0000);
      tc(2'd0, 1'b0, 8'h5A, 8'h00, 8'hFF, 8'h5A);
      repeat (2) @(posedge i_clk);
      #1;
      `CHK("masked interrupt", 1'b0, o_irq)
      apb(1'b1, aitc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
      @(posedge i_clk);
      #1;
      `CHK("interrupt", 1'b1, o_irq)
      rd(aitc_pkg::OFF_STATUS, 32'h0000_0003, 1'b0);
      @(posedge i_clk);
      #1;
      `CHK("cleared interrupt", 1'b0, o_irq)
      rd(aitc_pkg::OFF_STATUS, 32'h0000_0000, 1'b0);
      rd(aitc_pkg::OFF_TRACE_LO, last[31:0], 1'b0);
      rd(aitc_pkg::OFF_TRACE_HI, {16'h0000, last[47:32]}, 1'b0);
      rd(aitc_pkg::OFF_MATCH_CNT, 32'(hits), 1'b0);
      $display("test interrupt done");
      results();
   end
endmodule : aux_input_trigger_compare_bench
